// >>> dv/sfti_master.sv
// Serial link master model that frames commands towards the flash target
`timescale 1ns/1ps
module sfti_master (
  output logic      sck,
  output logic      cs_n,
  output logic      si,
  output logic      hold_n,
  input  wire logic so
);
  logic [7:0] tx_q [$];
  logic [7:0] rx_q [$];
  logic [7:0] rx;

  // Idle levels before the first frame
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
    hold_n = 1'b1;
    rx = 8'h00;
  end

  // ==========================================================
  // One frame, whole bytes MSB first plus optional stray bits
  task automatic frame(input int extra, input bit mode3, input int pause_at);
    sck = mode3;
    #160 cs_n = 1'b0;
    #160;
    rx_q = {};
    for (int i = 0; i < tx_q.size() * 8 + extra; i++) begin
      if (i / 8 == pause_at && i % 8 == 0) begin
        hold_n = 1'b0;
        si = ~si;
        #160 sck = 1'b0;
        #160 sck = 1'b1;
        #160 hold_n = 1'b1;
        #160;
      end
      sck = 1'b0;
      si = (i < tx_q.size() * 8) ? tx_q[i / 8][7 - i % 8] : 1'b1;
      #160 sck = 1'b1;
      #150 rx = {rx[6:0], so};
      if (i % 8 == 7) rx_q.push_back(rx);
      #10;
    end
    #160 sck = mode3;
    #160 cs_n = 1'b1;
    si = ~si; // Released line must not keep its last value
    #640;
  endtask : frame
endmodule : sfti_master

// >>> dv/sfti_target_tb.sv
// Self-checking bench for the serial flash target front end
`timescale 1ns/1ps
module sfti_target_tb;
  import sfti_pkg::*;
  logic                   clk, rst_n, guard_boost_n, boost_voltage, parallel_sel, arr_done;
  logic                   sck, cs_n, si, hold_n, so, so_oe, accel_on, standby, sleeping;
  logic                   write_busy_flag, write_latch_flag, accel_seen;
  logic                   pio_oe_seen, parallel_io_oe, erased;
  logic [7:0]             parallel_io_in, parallel_io_out, arr_rdata, d0, d1;
  logic [2:0]             block_guard_bits;
  logic [23:0]            a;
  logic [7:0]             fr [$];
  logic [34:0]            notes [$];
  sfti_pkg::sfti_arr_req_t arr_req;
  int                     num_errors, checks_done, seed, cnt;

  sfti_target i_sfti_target (.clk(clk), .rst_n(rst_n), .sck(sck), .cs_n(cs_n), .si(si),
    .hold_n(hold_n), .guard_boost_n(guard_boost_n), .boost_voltage(boost_voltage),
    .parallel_sel(parallel_sel), .parallel_io_in(parallel_io_in),
    .parallel_io_out(parallel_io_out), .parallel_io_oe(parallel_io_oe), .so(so), .so_oe(so_oe),
    .arr_rdata(arr_rdata), .arr_done(arr_done),
    .arr_req(arr_req), .write_busy_flag(write_busy_flag), .write_latch_flag(write_latch_flag),
    .block_guard_bits(block_guard_bits), .accel_on(accel_on), .standby(standby),
    .sleeping(sleeping));
  // Floated serial output shows the inverse of its last bit to the master
  sfti_master i_sfti_master (.sck(sck), .cs_n(cs_n), .si(si), .hold_n(hold_n),
    .so(so_oe ? so : ~so));

  // Clock and array read pattern per address, all ones once the array is cleared
  always #20 clk = ~clk;
  assign arr_rdata = erased ? 8'hFF : arr_req.addr[7:0] ^ 8'hC3;

  // Array side: slow wipe completion, noise on the byte bus
  always @(negedge clk) begin
    arr_done <= (cnt == 1);
    cnt <= arr_req.erase ? 250 : (cnt > 0 ? cnt - 1 : 0);
    accel_seen <= accel_seen | accel_on;
    pio_oe_seen <= pio_oe_seen | parallel_io_oe;
    erased <= erased | (arr_req.erase & arr_req.erase_all);
    parallel_io_in <= parallel_sel ? OP_STATUS_READ : 8'($random(seed));
  end

  // Each array request is matched against the oldest note
  always @(negedge clk) begin
    if (arr_req.we || arr_req.erase) begin
      check("array", {arr_req.erase, arr_req.erase_all, arr_req.we,
        arr_req.we ? {arr_req.addr, arr_req.wdata} : 32'h0},
        notes.size() > 0 ? notes.pop_front() : '1);
    end
  end

  // ==========================================================
  // Shared tasks
  task automatic check(input string what, input logic [34:0] seen, input logic [34:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic close_out();
    $display("Errors %0d, checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : close_out

  task automatic run(input logic [7:0] b [$], input int extra = 0, input bit m3 = 0,
                     input int p = -1);
    @(negedge clk);
    i_sfti_master.tx_q = b;
    i_sfti_master.frame(extra, m3, p);
  endtask : run

  task automatic status(input logic [7:0] exp, input bit m3 = 0, input int p = -1);
    run('{OP_STATUS_READ, 8'h00}, 0, m3, p);
    check("status", 35'(i_sfti_master.rx_q[1]), 35'(exp));
    check("so_oe", 35'(so_oe), 35'h0);
  endtask : status

  task automatic poll();
    for (int k = 0; k < 40; k++) begin
      run('{OP_STATUS_READ, 8'h00});
      if (i_sfti_master.rx_q[1][STAT_BUSY_POS] === 1'b0) break;
    end
    check("idle", 35'(i_sfti_master.rx_q[1]), 35'h0);
  endtask : poll

  // ==========================================================
  // Main sequence
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    guard_boost_n = 1'b1;
    boost_voltage = 1'b0;
    parallel_sel = 1'b0;
    parallel_io_in = 8'h00;
    arr_done = 1'b0;
    accel_seen = 1'b0;
    pio_oe_seen = 1'b0;
    erased = 1'b0;
    cnt = 0;
    seed = 32'h2BD3;
    num_errors = 0;
    checks_done = 0;
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
    repeat (10) @(negedge clk);
    check("standby", 35'(standby), 35'h1);
    status(8'h00);
    run('{OP_LATCH_ARM}, 0, 1);
    check("latch", 35'(write_latch_flag), 35'h1);
    status(8'h02, 1);
    status(8'h02, 1, 1);
    // Byte-wide status read: every rising edge takes a whole byte
    parallel_sel = 1'b1;
    run('{OP_STATUS_READ, 8'h00});
    check("parallel out", 35'(parallel_io_out), 35'h02);
    check("parallel oe", 35'(pio_oe_seen), 35'h1);
    check("parallel oe off", 35'(parallel_io_oe), 35'h0);
    parallel_sel = 1'b0;
    // Two-byte page write with a pause in the address
    a = 24'($random(seed)) & 24'h7FFF7F;
    d0 = 8'($random(seed));
    d1 = 8'($random(seed));
    boost_voltage = 1'b1;
    notes.push_back({3'b001, a, (a[7:0] ^ 8'hC3) & d0});
    notes.push_back({3'b001, a + 24'h1, ((a[7:0] + 8'h1) ^ 8'hC3) & d1});
    run('{OP_PAGE_WRITE, a[23:16], a[15:8], a[7:0], d0, d1}, 0, 0, 2);
    boost_voltage = 1'b0;
    check("accel", 35'(accel_seen), 35'h1);
    status(8'h00);
    // Stray bits make a write frame void
    run('{OP_LATCH_ARM});
    run('{OP_PAGE_WRITE, 8'h00, 8'h00, 8'h10, 8'h00}, 3);
    status(8'h02);
    run('{OP_LATCH_DISARM});
    status(8'h00);
    // Both wipe codes and the whole-array clear
    for (int k = 0; k < 3; k++) begin
      run('{OP_LATCH_ARM});
      if (k == 2) fr = '{OP_ARRAY_CLEAR};
      else fr = '{k == 0 ? OP_REGION_WIPE : OP_REGION_WIPE2, 8'h01, 8'h00, 8'h00};
      notes.push_back({1'b1, k == 2, 1'b0, 32'h0});
      run(fr);
      check("busy", 35'(write_busy_flag), 35'h1);
      check("standby", 35'(standby), 35'h0);
      status(8'h03);
      poll();
      check("standby", 35'(standby), 35'h1);
    end
    // Program into erased bytes: data lands exactly as sent
    run('{OP_LATCH_ARM});
    notes.push_back({3'b001, a, d0});
    run('{OP_PAGE_WRITE, a[23:16], a[15:8], a[7:0], d0});
    status(8'h00);
    // Guard every sector, then try to write under the guard pin
    guard_boost_n = 1'b0;
    run('{OP_LATCH_ARM});
    run('{OP_STATUS_WRITE, 8'h1C});
    check("guard", 35'(block_guard_bits), 35'h7);
    status(8'h1C);
    run('{OP_LATCH_ARM});
    run('{OP_PAGE_WRITE, 8'h00, 8'h00, 8'h00, 8'h55});
    status(8'h1E);
    run('{OP_STATUS_WRITE, 8'h00});
    guard_boost_n = 1'b1;
    status(8'h00);
    // Writes ignored after the sleep command
    run('{OP_SLEEP});
    check("sleeping", 35'(sleeping), 35'h1);
    run('{OP_LATCH_ARM});
    run('{OP_PAGE_WRITE, 8'h00, 8'h00, 8'h20, 8'hA5});
    status(8'h02);
    run('{OP_WAKE});
    check("sleeping", 35'(sleeping), 35'h0);
    check("notes left", 35'(notes.size()), 35'h0);
    close_out();
  end

  // Watchdog well beyond the expected run length
  initial begin
    #1000000;
    num_errors++;
    close_out();
  end
endmodule : sfti_target_tb

// >>> hdl/sfti_pkg.sv
// Constants, types and carrier structs of the serial flash target front end
//
// Overview of operation
// - Status read bits leave on falling clock edges
// - Command, address, data captured on rising edges
// - Parallel variant moves whole bytes per edge
// - Select high: deselected, output floated
// - No command before first select falling edge
// - Standby when deselected and nothing running
// - Pause low floats output, ignores clock, input
// - Guard pin low blocks writes to guarded area
// - Boost voltage enables accelerated programming
// - Works with clock modes zero and three
// - All transfers are whole eight-bit bytes
// - One to 256 data bytes per page
// - Programming only clears bits to zero
// - Region wipe or array clear sets ones
// - Completion reported through busy status flag
// - Status read returns current busy flag
// - Busy set during any internal write operation
// - Latch set by arm, cleared after writes
// - Writes execute only on byte-aligned clock count
// - After sleep command, writes are ignored
package sfti_pkg;

  // ==========================================================
  // Command codes
  localparam logic [7:0] OP_LATCH_ARM    = 8'h06;
  localparam logic [7:0] OP_LATCH_DISARM = 8'h04;
  localparam logic [7:0] OP_STATUS_READ  = 8'h05;
  localparam logic [7:0] OP_PAGE_WRITE   = 8'h02;
  localparam logic [7:0] OP_REGION_WIPE  = 8'h20;
  localparam logic [7:0] OP_REGION_WIPE2 = 8'hD8;
  localparam logic [7:0] OP_SLEEP        = 8'hB9;
  localparam logic [7:0] OP_WAKE         = 8'hAB;
  localparam logic [7:0] OP_STATUS_WRITE = 8'h01; // Arbitrary value
  localparam logic [7:0] OP_ARRAY_CLEAR  = 8'h60; // Arbitrary value

  // ==========================================================
  // Frame layout, in bytes after select falls
  localparam logic [9:0] CMD_LEN_SHORT  = 10'h001;
  localparam logic [9:0] CMD_LEN_STATUS = 10'h002;
  localparam logic [9:0] CMD_LEN_ADDR   = 10'h004;
  localparam logic [9:0] CMD_LEN_PAGE   = 10'h005;
  localparam logic [8:0] PAGE_BYTES     = 9'h100;
  localparam logic [2:0] LAST_BIT       = 3'h7;
  localparam logic [14:0] PIN_IDLE      = 15'h2C00; // Sync reset: select, pause, guard high

  // ==========================================================
  // Status byte layout and protection geometry
  localparam int         STAT_BUSY_POS  = 0;
  localparam int         STAT_LATCH_POS = 1;
  localparam int         STAT_GUARD_LSB = 2;
  localparam int         SECTOR_LSB     = 18;
  localparam logic [6:0] SECTOR_COUNT   = 7'h40;
  localparam logic [2:0] GUARD_RESET    = 3'h0;

  // ==========================================================
  // Internal write engine states
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_PROG  = 2'b01,
    ST_WIPE  = 2'b10,
    ST_STAT  = 2'b11
  } sfti_state_t;

  // Request to the storage array
  typedef struct packed {
    logic [23:0] addr;
    logic [7:0]  wdata;
    logic        we;
    logic        erase;
    logic        erase_all;
  } sfti_arr_req_t;

endpackage : sfti_pkg

// >>> hdl/sfti_target.sv
// Serial flash target front end: pin sampling, command decode, write engine
`timescale 1ns/1ps
module sfti_target (
  input  wire logic                   clk,
  input  wire logic                   rst_n,
  input  wire logic                   sck,
  input  wire logic                   cs_n,
  input  wire logic                   si,
  input  wire logic                   hold_n,
  input  wire logic                   guard_boost_n,
  input  wire logic                   boost_voltage,
  input  wire logic                   parallel_sel,
  input  wire logic [7:0]             parallel_io_in,
  output logic      [7:0]             parallel_io_out,
  output logic                        parallel_io_oe,
  output logic                        so,
  output logic                        so_oe,
  input  wire logic [7:0]             arr_rdata,
  input  wire logic                   arr_done,
  output sfti_pkg::sfti_arr_req_t     arr_req,
  output logic                        write_busy_flag,
  output logic                        write_latch_flag,
  output logic      [2:0]             block_guard_bits,
  output logic                        accel_on,
  output logic                        standby,
  output logic                        sleeping
);
  import sfti_pkg::*;

  // ==========================================================
  // Reset release and pin synchronisers
  logic [1:0]  rst_sync_r;
  logic        rst_sn;
  logic [14:0] pin_s1_r;
  logic [14:0] pin_s2_r;
  logic        sck_d_r;
  logic        cs_d_r;

  // Reset leaves through two flops
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) rst_sync_r <= 2'h0;
    else        rst_sync_r <= {rst_sync_r[0], 1'b1};
  end
  assign rst_sn = rst_sync_r[1];

  // Every pin passes two flops; third stage only for edge finding
  always_ff @(posedge clk or negedge rst_sn) begin
    if (!rst_sn) begin
      pin_s1_r <= PIN_IDLE;
      pin_s2_r <= PIN_IDLE;
      sck_d_r  <= 1'b0;
      cs_d_r   <= 1'b1;
    end else begin
      pin_s1_r <= {sck, cs_n, si, hold_n, guard_boost_n, boost_voltage, parallel_sel,
                   parallel_io_in};
      pin_s2_r <= pin_s1_r;
      sck_d_r  <= pin_s2_r[14];
      cs_d_r   <= pin_s2_r[13];
    end
  end

  // Named views of the synchronised pins
  wire       sck_q   = pin_s2_r[14];
  wire       cs_q    = pin_s2_r[13];
  wire       si_q    = pin_s2_r[12];
  wire       hold_q  = pin_s2_r[11];
  wire       guard_q = pin_s2_r[10];
  wire       boost_q = pin_s2_r[9];
  wire       par_q   = pin_s2_r[8];
  wire [7:0] pio_q   = pin_s2_r[7:0];

  // ==========================================================
  // Edge detection and framing
  wire live      = ~cs_q & hold_q;
  wire sck_rise  = live & sck_q & ~sck_d_r;
  wire sck_fall  = live & ~sck_q & sck_d_r;
  wire cs_fall   = ~cs_q & cs_d_r;
  wire cs_rise   = cs_q & ~cs_d_r;

  logic [2:0]  bit_cnt_r;
  logic [6:0]  in_shift_r;
  logic [9:0]  byte_cnt_r;
  logic [7:0]  cmd_r;
  logic [23:0] addr_r;
  logic [7:0]  page_buf [0:255];
  logic [7:0]  wr_idx_r;
  logic [8:0]  page_n_r;
  logic        armed_r;
  logic        latch_r;
  logic        sleep_r;
  logic [2:0]  guard_r;
  logic [7:0]  tx_r;
  logic        tx_en_r;
  logic        so_r;
  logic [7:0]  pio_out_r;
  sfti_state_t state_r;
  logic [7:0]  eng_idx_r;
  logic        ph_r;
  sfti_arr_req_t req_r;

  // Byte assembly: serial shift or whole parallel byte
  wire [7:0] rx_byte   = par_q ? pio_q : {in_shift_r, si_q};
  wire       byte_done = sck_rise & (par_q | (bit_cnt_r == LAST_BIT));
  wire       aligned   = par_q | (bit_cnt_r == 3'h0);
  wire       busy      = (state_r != ST_IDLE);
  wire       in_data   = (byte_cnt_r >= CMD_LEN_ADDR) & (cmd_r == OP_PAGE_WRITE);
  wire       stat_rd   = (byte_cnt_r == 10'h000) ? (rx_byte == OP_STATUS_READ)
                                                 : (cmd_r == OP_STATUS_READ);

  // Live status byte
  wire [7:0] status_byte = {3'h0, guard_r, latch_r, busy};

  // ==========================================================
  // Protection decode: top sectors guarded, count doubles per step
  wire [6:0] guard_span = 7'(7'h01 << (guard_r - 3'h1));
  wire [6:0] guard_low  = 7'(SECTOR_COUNT - guard_span);
  wire       guard_on   = ~guard_q & (guard_r != 3'h0);
  wire       addr_prot  = guard_on & ({1'b0, addr_r[23:SECTOR_LSB]} >= guard_low);

  // ==========================================================
  // Execution decode at select rise
  wire go_ok    = cs_rise & armed_r & aligned & ~busy;
  wire go_write = go_ok & latch_r & ~sleep_r;
  wire go_prog  = go_write & (cmd_r == OP_PAGE_WRITE) & (byte_cnt_r >= CMD_LEN_PAGE)
                  & ~addr_prot;
  wire go_wipe  = go_write & ((cmd_r == OP_REGION_WIPE) | (cmd_r == OP_REGION_WIPE2))
                  & (byte_cnt_r == CMD_LEN_ADDR) & ~addr_prot;
  wire go_clear = go_write & (cmd_r == OP_ARRAY_CLEAR)
                  & (byte_cnt_r == CMD_LEN_SHORT) & ~guard_on;
  wire go_stat  = go_write & (cmd_r == OP_STATUS_WRITE)
                  & (byte_cnt_r == CMD_LEN_STATUS);
  wire is_short = (byte_cnt_r == CMD_LEN_SHORT);
  wire go_arm   = go_ok & is_short & (cmd_r == OP_LATCH_ARM);
  wire go_dis   = go_ok & is_short & (cmd_r == OP_LATCH_DISARM);
  wire go_sleep = go_ok & is_short & (cmd_r == OP_SLEEP);
  wire go_wake  = go_ok & is_short & (cmd_r == OP_WAKE);
  wire eng_end;

  // Receive path: bit and byte counters, command and address
  always_ff @(posedge clk or negedge rst_sn) begin
    if (!rst_sn) begin
      bit_cnt_r  <= 3'h0;
      in_shift_r <= 7'h00;
      byte_cnt_r <= 10'h000;
      cmd_r      <= 8'h00;
      addr_r     <= 24'h000000;
    end else if (cs_q) begin
      bit_cnt_r  <= 3'h0;
      byte_cnt_r <= 10'h000;
    end else if (sck_rise) begin
      bit_cnt_r  <= par_q ? 3'h0 : 3'(bit_cnt_r + 3'h1);
      in_shift_r <= rx_byte[6:0];
      if (byte_done) begin
        if (byte_cnt_r != 10'h3FF) byte_cnt_r <= 10'(byte_cnt_r + 10'h001);
        if (byte_cnt_r == 10'h000) cmd_r <= rx_byte;
        if ((byte_cnt_r != 10'h000) && (byte_cnt_r < CMD_LEN_ADDR)) begin
          addr_r <= {addr_r[15:0], rx_byte};
        end
      end
    end
  end

  // Page buffer fill; later bytes past a page wrap over earlier ones
  always_ff @(posedge clk) begin
    if (byte_done & in_data & ~busy) page_buf[wr_idx_r] <= rx_byte;
  end

  always_ff @(posedge clk or negedge rst_sn) begin
    if (!rst_sn) begin
      wr_idx_r <= 8'h00;
      page_n_r <= 9'h000;
    end else if (cs_fall & ~busy) begin                    // Engine still reads the count
      wr_idx_r <= 8'h00;
      page_n_r <= 9'h000;
    end else if (byte_done & in_data & ~busy) begin
      wr_idx_r <= 8'(wr_idx_r + 8'h01);
      if (page_n_r != PAGE_BYTES) page_n_r <= 9'(page_n_r + 9'h001);
    end
  end

  // ==========================================================
  // Control flags: power-up arming, write latch, sleep, guard bits
  always_ff @(posedge clk or negedge rst_sn) begin
    if (!rst_sn) begin
      armed_r <= 1'b0;
      latch_r <= 1'b0;
      sleep_r <= 1'b0;
      guard_r <= GUARD_RESET;
    end else begin
      if (cs_fall) armed_r <= 1'b1;
      if (go_arm) latch_r <= 1'b1;
      else if (go_dis | eng_end) latch_r <= 1'b0;
      if (go_sleep) sleep_r <= 1'b1;
      else if (go_wake) sleep_r <= 1'b0;
      if (go_stat) guard_r <= addr_r[STAT_GUARD_LSB +: 3];
    end
  end

  // ==========================================================
  // Transmit path: status byte shifted out on falling edges
  always_ff @(posedge clk or negedge rst_sn) begin
    if (!rst_sn) begin
      tx_r      <= 8'h00;
      tx_en_r   <= 1'b0;
      so_r      <= 1'b0;
      pio_out_r <= 8'h00;
    end else if (cs_q) begin
      tx_en_r <= 1'b0;
    end else if (byte_done & stat_rd) begin
      tx_r    <= status_byte;
      tx_en_r <= 1'b1;
    end else if (sck_fall & tx_en_r) begin
      so_r      <= tx_r[7];
      tx_r      <= {tx_r[6:0], 1'b0};
      pio_out_r <= tx_r;
    end
  end

  // Outputs float when deselected or paused
  assign so              = so_r;
  assign so_oe           = live & tx_en_r & ~par_q;
  assign parallel_io_out = pio_out_r;
  assign parallel_io_oe  = live & tx_en_r & par_q;

  // ==========================================================
  // Write engine: page program, wipe, status update
  wire [7:0] prog_byte = arr_rdata & page_buf[eng_idx_r];
  wire       last_prog = (state_r == ST_PROG) & ph_r & ({1'b0, eng_idx_r} == 9'(page_n_r - 9'h001));
  assign eng_end = last_prog | ((state_r == ST_WIPE) & arr_done & ~req_r.erase)
                   | (state_r == ST_STAT);

  always_ff @(posedge clk or negedge rst_sn) begin
    if (!rst_sn) begin
      state_r   <= ST_IDLE;
      eng_idx_r <= 8'h00;
      ph_r      <= 1'b0;
      req_r     <= '0;
    end else begin
      req_r.we    <= 1'b0;
      req_r.erase <= 1'b0;
      req_r.erase_all <= 1'b0;
      case (state_r)
        ST_IDLE: begin
          eng_idx_r <= 8'h00;
          ph_r      <= 1'b0;
          if (go_prog) state_r <= ST_PROG;
          else if (go_wipe | go_clear) begin
            state_r         <= ST_WIPE;
            req_r.erase     <= 1'b1;
            req_r.erase_all <= go_clear;
            req_r.addr      <= addr_r;
          end else if (go_stat) state_r <= ST_STAT;
        end
        ST_PROG: begin
          req_r.addr <= {addr_r[23:8], 8'(addr_r[7:0] + eng_idx_r)};
          ph_r       <= ~ph_r;
          if (ph_r) begin
            req_r.wdata <= prog_byte;
            req_r.we    <= 1'b1;
            eng_idx_r   <= 8'(eng_idx_r + 8'h01);
            if (last_prog) state_r <= ST_IDLE;
          end
        end
        ST_WIPE: begin
          if (eng_end) state_r <= ST_IDLE;
        end
        ST_STAT: state_r <= ST_IDLE;
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // Status and power outputs
  assign arr_req          = req_r;
  assign write_busy_flag  = busy;
  assign write_latch_flag = latch_r;
  assign block_guard_bits = guard_r;
  assign accel_on         = boost_q & (state_r == ST_PROG);
  assign standby          = cs_q & ~busy;
  assign sleeping         = sleep_r;

  // ==========================================================
  // Assertions
  sequence s_wipe_pulse;
    req_r.erase ##1 !req_r.erase;
  endsequence

  a_desel_float:
  assert property (@(posedge clk) disable iff (!rst_sn) cs_q |-> !so_oe && !parallel_io_oe)
    else $error("output driven while deselected");

  a_pause_float:
  assert property (@(posedge clk) disable iff (!rst_sn)
    !hold_q |-> !so_oe && !parallel_io_oe && !sck_rise)
    else $error("output or capture active while paused");

  a_unarmed_idle:
  assert property (@(posedge clk) disable iff (!rst_sn)
    !armed_r |-> state_r == ST_IDLE && !latch_r)
    else $error("command taken before first select fall");

  a_prog_starts:
  assert property (@(posedge clk) disable iff (!rst_sn)
    go_prog |=> write_busy_flag ##1 (state_r == ST_PROG))
    else $error("busy not raised for program");

  a_latch_clears:
  assert property (@(posedge clk) disable iff (!rst_sn)
    $fell(write_busy_flag) |-> !write_latch_flag)
    else $error("latch still set after write finished");

  a_prog_clears_only:
  assert property (@(posedge clk) disable iff (!rst_sn)
    ph_r && state_r == ST_PROG |=> req_r.we && (req_r.wdata & ~$past(arr_rdata)) == 8'h00)
    else $error("program would set a bit");

  a_misaligned_skip:
  assert property (@(posedge clk) disable iff (!rst_sn)
    cs_rise && !aligned && !busy |=> state_r == ST_IDLE && latch_r == $past(latch_r))
    else $error("write executed on unaligned count");

  a_sleep_blocks:
  assert property (@(posedge clk) disable iff (!rst_sn)
    sleep_r && state_r == ST_IDLE |=> state_r == ST_IDLE)
    else $error("write started while sleeping");

  a_wipe_pulse:
  assert property (@(posedge clk) disable iff (!rst_sn)
    (go_wipe || go_clear) |=> s_wipe_pulse)
    else $error("wipe request not a single pulse");

  a_status_bit_out:
  assert property (@(posedge clk) disable iff (!rst_sn)
    sck_fall && tx_en_r && !cs_q |=> so == $past(tx_r[7]))
    else $error("status bit not shifted on falling edge");

  a_standby_idle:
  assert property (@(posedge clk) disable iff (!rst_sn)
    $rose(cs_q) && !busy |-> standby ##1 (standby || busy || !cs_q))
    else $error("standby not entered when deselected");

endmodule : sfti_target
